// ===== src/irq_pkg.sv
/*
 * Shared constants and carriers for the two-level interrupt handler.
 * Assumes one system clock domain and an asynchronous active-low reset.
 */
`default_nettype none
package irq_pkg;
    localparam int          NUM_SOURCES       = 17;
    localparam int          VEC_WIDTH         = 16;
    localparam int          IDX_WIDTH         = 5;
    localparam int          GLOBAL_EN_BIT     = 7;
    localparam int          VEC_STEP          = 8;
    localparam logic [15:0] VEC_BASE          = 16'h0003;
    localparam logic [31:0] AUTO_CLEAR_MASK   = 32'h0000_000f;
    localparam logic [31:0] PRIO_RESET        = 32'h0000_0000;
    localparam logic [31:0] PEND_RESET        = 32'h0000_0000;

    typedef enum logic [1:0] {
        cpu_idle,
        cpu_call,
        cpu_hold
    } call_state_e;

    typedef struct packed {
        logic                 call;
        logic [VEC_WIDTH-1:0] vector;
        logic [IDX_WIDTH-1:0] source;
        logic                 high;
    } call_req_s;
endpackage : irq_pkg
`default_nettype wire

// ===== src/two_level_interrupt_handler.sv
/*
 * Interrupt handler: pending flags, enables, two priority levels and nesting.
 * Assumes the CPU pulses i_insn_done at each instruction boundary, pulses
 * i_return_from_interrupt_done when a return_from_interrupt completes, and accepts a
 * long_call_to_vector request with i_call_ack. Source events are synchronous.
 */
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Source event sets its pending flag
// - Request needs pending, own enable, global enable
// - Call source vector after current instruction
// - Return resumes interrupted program flow
// - Flags set even while disabled
// - Some flags auto-clear on vectoring
// - Still-pending flag re-enters after one instruction
// - Global enable is enable bit seven
// - Global off blocks all, keeps pending
// - Software set of flag acts as event
// - Each source has own enable bit
// - High preempts low; high never preempted
// - All priorities low after reset
// - Higher level first, fixed order ties
// - Sample and decode every clock
// - Equal-level request waits past return plus one
module two_level_interrupt_handler
    import irq_pkg::*;
#(
    parameter int NSRC = NUM_SOURCES
) (
    // Clock and reset
    input  wire logic            i_clock,
    input  wire logic            i_arst_n,
    // Sources and software access
    input  wire logic [NSRC-1:0] i_src_event,
    input  wire logic [NSRC-1:0] i_sw_set,
    input  wire logic [NSRC-1:0] i_sw_clear,
    // Configuration
    input  wire logic [7:0]      i_irq_enable_reg,
    input  wire logic [NSRC-1:0] i_src_enable,
    input  wire logic [NSRC-1:0] i_prio_wr,
    input  wire logic [NSRC-1:0] i_prio_val,
    // CPU side
    input  wire logic            i_insn_done,
    input  wire logic            i_return_from_interrupt_done,
    input  wire logic            i_call_ack,
    output logic                 o_call,
    output logic [VEC_WIDTH-1:0] o_vector,
    output logic [IDX_WIDTH-1:0] o_source,
    output logic                 o_irq_request,
    output logic [NSRC-1:0]      o_pending,
    output logic [NSRC-1:0]      o_prio,
    output logic [1:0]           o_in_service
);

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    logic [NSRC-1:0] pending;
    logic [NSRC-1:0] prio;
    logic            svc_low;
    logic            svc_high;
    logic            gap;
    call_state_e     state;
    call_req_s       req;
    logic            global_en;
    logic [NSRC-1:0] armed;
    logic [NSRC-1:0] eligible;
    logic            sel_valid;
    logic [IDX_WIDTH-1:0] sel_idx;
    logic            sel_high;
    logic [NSRC-1:0] ack_clear;

    assign global_en = i_irq_enable_reg[GLOBAL_EN_BIT];
    assign armed     = global_en ? (pending & i_src_enable) : '0;

    //------------------------------------------------------------
    // Priority decode
    //------------------------------------------------------------
    // Blocked while high in service; low allowed only when idle
    always_comb begin
        eligible = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (prio[i])
                eligible[i] = armed[i] && !svc_high;
            else
                eligible[i] = armed[i] && !svc_high && !svc_low;
        end
    end

    always_comb begin
        sel_valid = 1'b0;
        sel_idx   = '0;
        sel_high  = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (eligible[i] && !prio[i]) begin
                sel_valid = 1'b1;
                sel_idx   = IDX_WIDTH'(i);
                sel_high  = 1'b0;
            end
        end
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (eligible[i] && prio[i]) begin
                sel_valid = 1'b1;
                sel_idx   = IDX_WIDTH'(i);
                sel_high  = 1'b1;
            end
        end
    end

    //------------------------------------------------------------
    // Pending flags
    //------------------------------------------------------------
    always_comb begin
        ack_clear = '0;
        if (state == cpu_call && i_call_ack && AUTO_CLEAR_MASK[req.source])
            ack_clear[req.source] = 1'b1;
    end

    // Set wins over clear
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pending <= PEND_RESET[NSRC-1:0];
        end else begin
            pending <= (pending & ~(i_sw_clear | ack_clear))
                     | i_src_event | i_sw_set;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prio <= PRIO_RESET[NSRC-1:0];
        end else begin
            for (int i = 0; i < NSRC; i++) begin
                if (i_prio_wr[i])
                    prio[i] <= i_prio_val[i];
            end
        end
    end

    //------------------------------------------------------------
    // In-service tracking
    //------------------------------------------------------------
    // Return releases the most recently entered level
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            svc_low  <= 1'b0;
            svc_high <= 1'b0;
        end else if (state == cpu_call && i_call_ack) begin
            if (req.high)
                svc_high <= 1'b1;
            else
                svc_low  <= 1'b1;
        end else if (i_return_from_interrupt_done) begin
            if (svc_high)
                svc_high <= 1'b0;
            else
                svc_low  <= 1'b0;
        end
    end

    // One instruction must run after each return
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gap <= 1'b0;
        end else if (i_return_from_interrupt_done) begin
            gap <= 1'b1;
        end else if (i_insn_done) begin
            gap <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Vectoring sequencer
    //------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= cpu_idle;
            req   <= '0;
        end else begin
            case (state)
                cpu_idle: begin
                    // Decoded every clock, taken at a boundary
                    if (sel_valid && i_insn_done && !gap && !i_return_from_interrupt_done) begin
                        state      <= cpu_call;
                        req.call   <= 1'b1;
                        req.source <= sel_idx;
                        req.high   <= sel_high;
                        // Each source owns a fixed vector slot
                        req.vector <= VEC_BASE + VEC_WIDTH'(VEC_STEP * int'(sel_idx));
                    end
                end
                cpu_call: begin
                    if (i_call_ack) begin
                        state    <= cpu_hold;
                        req.call <= 1'b0;
                    end
                end
                cpu_hold: begin
                    state <= cpu_idle;
                end
                default: begin
                    state <= cpu_idle;
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // Registered outputs
    //------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_call        <= 1'b0;
            o_vector      <= '0;
            o_source      <= '0;
            o_irq_request <= 1'b0;
            o_pending     <= '0;
            o_prio        <= '0;
            o_in_service  <= '0;
        end else begin
            // Call drops in the cycle after acceptance
            o_call        <= req.call && !(state == cpu_call && i_call_ack);
            o_vector      <= req.vector;
            o_source      <= req.source;
            o_irq_request <= sel_valid;
            o_pending     <= pending;
            o_prio        <= prio;
            o_in_service  <= {svc_high, svc_low};
        end
    end

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    a_event_sets_flag: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        i_src_event[0] |=> pending[0])
        else $error("event did not set pending flag");

    a_global_blocks: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        !global_en |-> !sel_valid)
        else $error("request while globally disabled");

    a_disabled_no_req: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (armed == '0) |=> !o_irq_request)
        else $error("request without enabled pending flag");

    a_call_on_boundary: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        $rose(req.call) |-> $past(i_insn_done && !gap && !i_return_from_interrupt_done))
        else $error("call raised off an instruction boundary");

    a_high_not_preempted: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        $rose(req.call) |-> !$past(svc_high))
        else $error("high level handler preempted");

    a_gap_after_return: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        i_return_from_interrupt_done |=> (gap && !req.call))
        else $error("no instruction after return");

    a_auto_clear: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (state == cpu_call && i_call_ack && AUTO_CLEAR_MASK[req.source]
         && !i_src_event[req.source] && !i_sw_set[req.source])
        |=> !pending[$past(req.source)])
        else $error("auto-clear flag not cleared on vectoring");

    a_high_wins: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (sel_valid && |(eligible & prio)) |-> sel_high)
        else $error("low level chosen over high");

    a_level_tracked: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (state == cpu_call && i_call_ack && req.high) |=> svc_high)
        else $error("high level not marked in service");

    a_flag_kept: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (($past(pending) & ~pending & ~$past(i_sw_clear | ack_clear)) == '0))
        else $error("pending flag lost without a clear");

    a_sw_set_flag: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (i_sw_set != '0) |=> ((pending & $past(i_sw_set)) == $past(i_sw_set)))
        else $error("software set did not raise pending flag");

    a_low_waits: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (svc_low && sel_valid) |-> sel_high)
        else $error("low request chosen while low in service");

    a_level_release: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (i_return_from_interrupt_done && svc_high && !(state == cpu_call && i_call_ack))
        |=> (!svc_high && $stable(svc_low)))
        else $error("return did not release the high level");

    a_irq_follows: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        sel_valid |=> o_irq_request)
        else $error("request output missing");

    a_prio_write: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (i_prio_wr != '0) |=> ((prio & $past(i_prio_wr)) == ($past(i_prio_val) & $past(i_prio_wr))))
        else $error("priority bit not written");

endmodule : two_level_interrupt_handler

`default_nettype wire

// ===== bench/cpu_core_model.sv
/*
 * Behavioural CPU core facing the interrupt handler.
 * Assumes the handler's outputs are registered on the rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_arst_n,
    // Bench control
    input  wire logic i_slow,
    // Handler side
    input  wire logic i_call,
    output var  logic o_insn_done,
    output var  logic o_call_ack
);
    logic [1:0] phase;

    // -----------------------------
    // Instruction boundaries and call acceptance
    // -----------------------------
    always_ff @(negedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase       <= 2'h0;
            o_insn_done <= 1'b0;
            o_call_ack  <= 1'b0;
        end else begin
            phase       <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            o_insn_done <= !i_slow || phase == 2'h0;
            o_call_ack  <= i_call && (!i_slow || phase == 2'h2);
        end
    end
endmodule : cpu_core_model
`default_nettype wire

// ===== bench/two_level_interrupt_handler_bench.sv
/*
 * Self-checking bench for the interrupt handler.
 * Assumes a CPU model answers calls; bench plays software and sources.
 */
`timescale 1ns/10ps
`default_nettype none
module two_level_interrupt_handler_bench;
    import irq_pkg::*;
    logic clk, rst_n, return_from_interrupt, slow, insn, ack, call, irq;
    logic [16:0] ev, sws, swc, en, pwr, pval, pend, prio;
    logic [7:0]  ier;
    logic [15:0] vec;
    logic [4:0]  src;
    logic [1:0]  insv;
    int          err_count, n_checks;

    two_level_interrupt_handler u_dut (.i_clock(clk), .i_arst_n(rst_n), .i_src_event(ev),
        .i_sw_set(sws), .i_sw_clear(swc), .i_irq_enable_reg(ier), .i_src_enable(en),
        .i_prio_wr(pwr), .i_prio_val(pval), .i_insn_done(insn), .i_return_from_interrupt_done(return_from_interrupt),
        .i_call_ack(ack), .o_call(call), .o_vector(vec), .o_source(src),
        .o_irq_request(irq), .o_pending(pend), .o_prio(prio), .o_in_service(insv));
    cpu_core_model u_cpu (.i_clock(clk), .i_arst_n(rst_n), .i_slow(slow), .i_call(call),
        .o_insn_done(insn), .o_call_ack(ack));

    // -----------------------------
    // Shared tasks
    // -----------------------------
    task chk(input string n, input logic [16:0] e, input logic [16:0] s);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task pulse(input logic [16:0] m, input logic sw);
        @(negedge clk);
        if (sw) sws = m; else ev = m;
        @(negedge clk);
        ev = 17'h00000;
        sws = 17'h00000;
        @(negedge clk);
    endtask : pulse

    task quiet(input int n);
        repeat (n) begin
            @(negedge clk);
            chk("call", 17'h00000, {16'h0000, call});
        end
    endtask : quiet

    task clr_ret(input logic [16:0] m);
        @(negedge clk);
        swc = m;
        @(negedge clk);
        swc = 17'h00000;
        return_from_interrupt = 1'b1;
        @(negedge clk);
        return_from_interrupt = 1'b0;
        repeat (2) @(negedge clk);
    endtask : clr_ret

    task serve(input int s, input logic [1:0] ins);
        int k;
        k = 0;
        while (call !== 1'b1 && k < 60) begin
            @(negedge clk);
            k++;
        end
        chk("call", 17'h00001, {16'h0000, call});
        chk("vector", {1'b0, VEC_BASE + 16'(VEC_STEP * s)}, {1'b0, vec});
        chk("source", 17'(s), {12'h000, src});
        k = 0;
        while (call !== 1'b0 && k < 20) begin
            @(negedge clk);
            k++;
        end
        repeat (2) @(negedge clk);
        chk("in_service", {15'h0000, ins}, {15'h0000, insv});
    endtask : serve

    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    // -----------------------------
    // Scenarios
    // -----------------------------
    task t_reset;
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk("prio", 17'h00000, prio);
        chk("pending", 17'h00000, pend);
        chk("in_service", 17'h00000, {15'h0000, insv});
        $display("test reset done");
    endtask : t_reset

    task t_global_off;
        ier = 8'h00;
        pulse(17'h00004, 1'b0);
        chk("pending2", 17'h00001, {16'h0000, pend[2]});
        quiet(10);
        chk("request", 17'h00000, {16'h0000, irq});
        ier = 8'h80;
        @(negedge clk);
        chk("request", 17'h00001, {16'h0000, irq});
        serve(2, 2'b01);
        chk("pending2", 17'h00000, {16'h0000, pend[2]});
        clr_ret(17'h00000);
        $display("test global enable done");
    endtask : t_global_off

    task t_order;
        @(negedge clk);
        pwr = 17'h00200;
        pval = 17'h00200;
        @(negedge clk);
        pwr = 17'h00000;
        repeat (2) @(negedge clk);
        chk("prio", 17'h00200, prio);
        pulse(17'h00250, 1'b0);
        serve(9, 2'b10);
        quiet(15);
        clr_ret(17'h00200);
        serve(4, 2'b01);
        clr_ret(17'h00010);
        serve(6, 2'b01);
        clr_ret(17'h00040);
        $display("test order done");
    endtask : t_order

    task t_preempt;
        pulse(17'h00080, 1'b0);
        serve(7, 2'b01);
        pulse(17'h00200, 1'b0);
        serve(9, 2'b11);
        clr_ret(17'h00200);
        chk("in_service", 17'h00001, {15'h0000, insv});
        clr_ret(17'h00080);
        chk("in_service", 17'h00000, {15'h0000, insv});
        $display("test preempt done");
    endtask : t_preempt

    task t_reenter;
        slow = 1'b1;
        pulse(17'h00020, 1'b0);
        serve(5, 2'b01);
        clr_ret(17'h00000);
        serve(5, 2'b01);
        clr_ret(17'h00020);
        slow = 1'b0;
        $display("test reentry done");
    endtask : t_reenter

    task t_soft;
        pulse(17'h01000, 1'b0);
        quiet(10);
        chk("pending12", 17'h00001, {16'h0000, pend[12]});
        pulse(17'h00800, 1'b1);
        serve(11, 2'b01);
        clr_ret(17'h01800);
        $display("test software set done");
    endtask : t_soft

    // -----------------------------
    // Clock, watchdog and main sequence
    // -----------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #50us;
        err_count++;
        end_sim();
    end

    initial begin
        {rst_n, return_from_interrupt, slow} = 3'h0;
        {ev, sws, swc, pwr, pval} = {5{17'h00000}};
        en = 17'h1efff;
        ier = 8'h80;
        err_count = 0;
        n_checks = 0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_reset();
        t_global_off();
        t_order();
        t_preempt();
        t_reenter();
        t_soft();
        t_reset();
        end_sim();
    end
endmodule : two_level_interrupt_handler_bench
`default_nettype wire
